// ---- design/dfr_manager.sv ----
// Overview of operation
// [RQ1] no usb activity within interval: stop drive, latch usb fault
// [RQ2] usb interval value 9999 disables the usb check
// [RQ3] brake sequence error trips with one of four codes, only when enabled
// [RQ4] internal circuit fault stops drive with code 13
// [RQ5] legacy panel shows five grouped faults as code 14, live and history
// [RQ6] every reset clears thermal integration and retry counter
// [RQ7] reset takes about one second before normal running resumes
// [RQ8] stop key resets only while a major fault is latched
// [RQ9] operator reapplies power only after panel indicator is dark
// [RQ10] external clear held over 0.1 s requests a reset
// [RQ11] external clear held keeps reset and flickers the error display
// [RQ12] energization and run hours count 0..65535 then wrap
// [RQ13] panel hours shown in tens of hours, max 6553, then restart
// [RQ14] writing 1 to history clear erases the fault history
// [RQ15] history clear refused while write guard equals 1
// [RQ16] retry exhaustion trips only with a nonzero retry limit
// [RQ17] trip keeps drive stopped until an accepted reset completes
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module dfr_manager #(
  parameter int TICK_CYCLES = dfr_pkg::TICK_CYCLES_DEF,
  parameter int CLEAR_CYCLES = dfr_pkg::CLEAR_CYCLES_DEF,
  parameter int HOUR_TICKS = dfr_pkg::HOUR_TICKS_DEF
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic usb_activity,
  input wire logic brake_seq_error,
  input wire logic [1:0] brake_seq_sel,
  input wire logic internal_circuit_fault,
  input wire logic line_input_fault,
  input wire logic analog_input_fault,
  input wire logic inrush_overheat_fault,
  input wire logic pe2_group_fault,
  input wire logic retry_attempt,
  input wire logic panel_stop_key,
  input wire logic external_clear_input,
  input wire logic legacy_panel,
  input wire logic run_command,
  output logic drive_stop,
  output logic [7:0] panel_code,
  output logic err_flicker,
  output logic thermal_clear,
  output logic reset_busy,
  output logic irq
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  generate
    if (TICK_CYCLES < 2 || CLEAR_CYCLES < 2 || HOUR_TICKS < 2)
    begin : g_bad_param
      $error("dfr_manager: counts must be at least 2");
    end
  endgenerate

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int CW = $clog2(CLEAR_CYCLES + 1);
  localparam int HW = $clog2(HOUR_TICKS + 1);
  localparam int SYN = 14;

  typedef struct packed {
    logic [SYN-1:0] s1;
    logic [SYN-1:0] s2;
    logic [2:0] s3;
    dfr_pkg::dfr_state_t st;
    logic [TW-1:0] tick_cnt;
    logic [HW-1:0] hour_cnt;
    logic [CW-1:0] clr_cnt;
    logic [3:0] rst_ticks;
    logic [15:0] usb_cnt;
    logic [7:0] retry_cnt;
    logic [7:0] code;
    logic [15:0] hist;
    logic brake_en;
    logic [1:0] guard;
    logic [15:0] usb_interval;
    logic [7:0] retry_limit;
    logic [15:0] power_hours;
    logic [15:0] run_hours;
    logic [dfr_pkg::EV_W-1:0] ev;
    logic [dfr_pkg::EV_W-1:0] mask;
    logic flick;
    logic therm;
    logic [15:0] rdata;
  } dfr_regs_t;

  dfr_regs_t r;
  dfr_regs_t next_r;

  // ---------------------------------------------------------------
  // legacy panel mapping
  // ---------------------------------------------------------------
  function automatic logic [7:0] dfr_map(input logic [7:0] c,
                                         input logic legacy);
    logic grouped;
    grouped = (c == dfr_pkg::FC_USB) || (c == dfr_pkg::FC_LINE) ||
              (c == dfr_pkg::FC_ANALOG) || (c == dfr_pkg::FC_INRUSH) ||
              (c == dfr_pkg::FC_PE2);
    return (legacy && grouped) ? dfr_pkg::FC_GROUPED : c; // [RQ5]
  endfunction

  logic [SYN-1:0] pins;
  logic tick;
  logic usb_edge;
  logic retry_edge;
  logic key_edge;
  logic clr_held;
  logic [7:0] new_code;
  logic [dfr_pkg::EV_W-1:0] ev_set;
  logic [dfr_pkg::EV_W-1:0] w1c;
  logic usb_due;
  logic retry_due;
  logic enter_reset;

  // code select rides the same two stages as its error line
  assign pins = {usb_activity, brake_seq_sel, run_command, legacy_panel,
                 external_clear_input, panel_stop_key, retry_attempt,
                 pe2_group_fault, inrush_overheat_fault,
                 analog_input_fault, line_input_fault,
                 internal_circuit_fault, brake_seq_error};

  // ---------------------------------------------------------------
  // combinational next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.s1 = pins;
    next_r.s2 = r.s1;
    next_r.s3 = {r.s2[6], r.s2[7], r.s2[13]};
    next_r.therm = 1'b0;
    next_r.rdata = 16'h0000;
    tick = (r.tick_cnt == TW'(TICK_CYCLES - 1));
    next_r.tick_cnt = tick ? '0 : r.tick_cnt + TW'(1);
    usb_edge = r.s2[13] && !r.s3[0];
    retry_edge = r.s2[6] && !r.s3[2];
    key_edge = r.s2[7] && !r.s3[1];
    clr_held = (r.clr_cnt == CW'(CLEAR_CYCLES)); // [RQ10]
    ev_set = '0;
    new_code = dfr_pkg::FC_NONE;
    enter_reset = 1'b0;

    // external clear hold timer, saturating
    if (!r.s2[8])
      next_r.clr_cnt = '0;
    else if (!clr_held)
      next_r.clr_cnt = r.clr_cnt + CW'(1);

    // hour counters wrap naturally at 16 bits
    if (tick)
    begin
      if (r.hour_cnt == HW'(HOUR_TICKS - 1))
      begin
        next_r.hour_cnt = '0;
        next_r.power_hours = r.power_hours + 16'h0001; // [RQ12]
        if (r.st == dfr_pkg::DFR_ST_RUN && r.s2[10])
          next_r.run_hours = r.run_hours + 16'h0001; // [RQ12]
      end
      else
        next_r.hour_cnt = r.hour_cnt + HW'(1);
    end

    // usb watchdog in ticks
    usb_due = (r.usb_interval != dfr_pkg::USB_CHECK_OFF) && // [RQ2]
              (r.usb_cnt >= r.usb_interval);
    if (usb_edge || r.st != dfr_pkg::DFR_ST_RUN ||
        r.usb_interval == dfr_pkg::USB_CHECK_OFF)
      next_r.usb_cnt = 16'h0000;
    else if (tick && !usb_due)
      next_r.usb_cnt = r.usb_cnt + 16'h0001;

    if (retry_edge && r.retry_cnt != 8'hFF)
      next_r.retry_cnt = r.retry_cnt + 8'h01;
    retry_due = (r.retry_limit != 8'h00) && // [RQ16]
                (r.retry_cnt >= r.retry_limit);

    // fault priority: internal, brake, usb, grouped inputs, retry
    if (r.s2[1])
    begin
      new_code = dfr_pkg::FC_INTERNAL; // [RQ4]
      ev_set[dfr_pkg::EV_INTERNAL] = 1'b1;
    end
    else if (r.s2[0] && r.brake_en)
    begin
      new_code = dfr_pkg::FC_BRAKE_BASE + {6'h00, r.s2[12:11]}; // [RQ3]
      ev_set[dfr_pkg::EV_BRAKE] = 1'b1;
    end
    else if (usb_due)
    begin
      new_code = dfr_pkg::FC_USB; // [RQ1]
      ev_set[dfr_pkg::EV_USB] = 1'b1;
    end
    else if (|r.s2[5:2])
    begin
      new_code = r.s2[2] ? dfr_pkg::FC_LINE :
                 r.s2[3] ? dfr_pkg::FC_ANALOG :
                 r.s2[4] ? dfr_pkg::FC_INRUSH : dfr_pkg::FC_PE2;
      ev_set[dfr_pkg::EV_GROUP] = 1'b1;
    end
    else if (retry_due)
    begin
      new_code = dfr_pkg::FC_RETRY; // [RQ16]
      ev_set[dfr_pkg::EV_RETRY] = 1'b1;
    end
    if (r.st != dfr_pkg::DFR_ST_RUN)
      ev_set = '0;

    unique case (r.st)
      dfr_pkg::DFR_ST_RESET:
      begin
        if (clr_held)
        begin
          // hold in reset while the clear input stays on
          next_r.rst_ticks = 4'h0; // [RQ11]
          if (tick)
            next_r.flick = !r.flick; // [RQ11]
        end
        else
        begin
          next_r.flick = 1'b0;
          if (tick)
            next_r.rst_ticks = r.rst_ticks + 4'h1;
          if (r.rst_ticks == 4'(dfr_pkg::RESET_TICKS)) // [RQ7]
          begin
            next_r.st = dfr_pkg::DFR_ST_RUN;
            ev_set[dfr_pkg::EV_RESET_DONE] = 1'b1;
          end
        end
      end
      dfr_pkg::DFR_ST_RUN:
      begin
        if (clr_held)
          enter_reset = 1'b1; // [RQ10]
        else if (new_code != dfr_pkg::FC_NONE)
        begin
          next_r.st = dfr_pkg::DFR_ST_TRIP; // [RQ17]
          next_r.code = new_code;
          next_r.hist = {r.hist[7:0], new_code};
        end
      end
      dfr_pkg::DFR_ST_TRIP:
      begin
        // stop key only counts as reset with a major fault latched
        if (clr_held || key_edge) // [RQ8]
          enter_reset = 1'b1;
      end
      default:
        enter_reset = 1'b1;
    endcase

    if (enter_reset)
    begin
      next_r.st = dfr_pkg::DFR_ST_RESET;
      next_r.rst_ticks = 4'h0;
      next_r.code = dfr_pkg::FC_NONE;
      next_r.retry_cnt = 8'h00; // [RQ6]
      next_r.therm = 1'b1; // [RQ6]
    end

    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    w1c = '0;
    if (reg_wr)
    begin
      unique case (reg_addr)
        dfr_pkg::REG_CTRL:
        begin
          next_r.brake_en = reg_wdata[dfr_pkg::CTRL_BRAKE_EN];
          next_r.guard = reg_wdata[dfr_pkg::CTRL_GUARD_LSB +: 2];
        end
        dfr_pkg::REG_USB_INTERVAL:
          next_r.usb_interval = reg_wdata;
        dfr_pkg::REG_RETRY_LIMIT:
          next_r.retry_limit = reg_wdata[7:0];
        dfr_pkg::REG_HIST_CLEAR:
          if (reg_wdata == dfr_pkg::HIST_CLEAR_CMD && // [RQ14]
              r.guard != dfr_pkg::GUARD_LOCKED) // [RQ15]
            next_r.hist = {dfr_pkg::FC_NONE, dfr_pkg::FC_NONE};
        dfr_pkg::REG_IRQ_STATUS:
          w1c = reg_wdata[dfr_pkg::EV_W-1:0];
        dfr_pkg::REG_IRQ_MASK:
          next_r.mask = reg_wdata[dfr_pkg::EV_W-1:0];
        default:
          w1c = '0;
      endcase
    end
    // a new event beats a clear in the same cycle
    next_r.ev = (r.ev & ~w1c) | ev_set;

    if (reg_rd)
    begin
      unique case (reg_addr)
        dfr_pkg::REG_CTRL:
          next_r.rdata = {13'h0000, r.guard, r.brake_en};
        dfr_pkg::REG_USB_INTERVAL:
          next_r.rdata = r.usb_interval;
        dfr_pkg::REG_RETRY_LIMIT:
          next_r.rdata = {8'h00, r.retry_limit};
        dfr_pkg::REG_STATUS:
          next_r.rdata = {5'h00, r.st, dfr_map(r.code, r.s2[9])};
        dfr_pkg::REG_HISTORY:
          next_r.rdata = {dfr_map(r.hist[15:8], r.s2[9]), // [RQ5]
                          dfr_map(r.hist[7:0], r.s2[9])};
        dfr_pkg::REG_POWER_HOURS:
          next_r.rdata = r.power_hours;
        dfr_pkg::REG_RUN_HOURS:
          next_r.rdata = r.run_hours;
        dfr_pkg::REG_PANEL_HOURS:
          next_r.rdata = r.power_hours / dfr_pkg::HOURS_DISPLAY_DIV; // [RQ13]
        dfr_pkg::REG_IRQ_STATUS:
          next_r.rdata = {10'h000, r.ev};
        dfr_pkg::REG_IRQ_MASK:
          next_r.rdata = {10'h000, r.mask};
        default:
          next_r.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0;
      // power-on starts a full reset sequence
      r.st <= dfr_pkg::DFR_ST_RESET;
      r.therm <= 1'b1; // [RQ6]
      r.usb_interval <= dfr_pkg::USB_CHECK_OFF;
    end
    else
      r <= next_r;
  end

  assign drive_stop = (r.st != dfr_pkg::DFR_ST_RUN); // [RQ17]
  assign panel_code = dfr_map(r.code, r.s2[9]); // [RQ5]
  assign err_flicker = r.flick;
  assign thermal_clear = r.therm;
  assign reset_busy = (r.st == dfr_pkg::DFR_ST_RESET);
  assign irq = |(r.ev & r.mask);
  assign reg_rdata = r.rdata;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_usb_trip;
    @(posedge clock) disable iff (!reset_n)
    (r.st == dfr_pkg::DFR_ST_RUN && usb_due && !r.s2[1] &&
     !(r.s2[0] && r.brake_en) && !clr_held)
    |=> (r.st == dfr_pkg::DFR_ST_TRIP && r.code == dfr_pkg::FC_USB);
  endproperty
  a_usb_trip: assert property (p_usb_trip) // [RQ1]
    else $error("usb timeout did not trip");

  property p_usb_off;
    @(posedge clock) disable iff (!reset_n)
    (r.usb_interval == dfr_pkg::USB_CHECK_OFF) |=>
    !$rose(r.st == dfr_pkg::DFR_ST_TRIP && r.code == dfr_pkg::FC_USB);
  endproperty
  a_usb_off: assert property (p_usb_off) // [RQ2]
    else $error("usb check active while disabled");

  property p_brake_off;
    @(posedge clock) disable iff (!reset_n)
    !r.brake_en |=> (r.code < dfr_pkg::FC_BRAKE_BASE ||
                     r.code > dfr_pkg::FC_BRAKE_BASE + 8'h03 ||
                     $stable(r.code));
  endproperty
  a_brake_off: assert property (p_brake_off) // [RQ3]
    else $error("brake fault latched while disabled");

  property p_internal;
    @(posedge clock) disable iff (!reset_n)
    (r.st == dfr_pkg::DFR_ST_RUN && r.s2[1] && !clr_held)
    |=> drive_stop && r.code == dfr_pkg::FC_INTERNAL;
  endproperty
  a_internal: assert property (p_internal) // [RQ4]
    else $error("internal fault not reported as 13");

  property p_legacy;
    @(posedge clock) disable iff (!reset_n)
    (r.s2[9] && r.code == dfr_pkg::FC_USB) |->
    panel_code == dfr_pkg::FC_GROUPED;
  endproperty
  a_legacy: assert property (p_legacy) // [RQ5]
    else $error("grouped code not shown on legacy panel");

  property p_reset_clear;
    @(posedge clock) disable iff (!reset_n)
    $rose(reset_busy) |-> thermal_clear && r.retry_cnt == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [RQ6]
    else $error("reset did not clear thermal and retries");

  property p_key_ignored;
    @(posedge clock) disable iff (!reset_n)
    (r.st == dfr_pkg::DFR_ST_RUN && key_edge && !clr_held) |=>
    !$rose(reset_busy);
  endproperty
  a_key_ignored: assert property (p_key_ignored) // [RQ8]
    else $error("stop key reset without a fault");

  property p_clear_hold;
    @(posedge clock) disable iff (!reset_n)
    clr_held |=> reset_busy;
  endproperty
  a_clear_hold: assert property (p_clear_hold) // [RQ11]
    else $error("not in reset while clear held");

  property p_hist_guard;
    @(posedge clock) disable iff (!reset_n)
    (reg_wr && reg_addr == dfr_pkg::REG_HIST_CLEAR &&
     r.guard == dfr_pkg::GUARD_LOCKED &&
     (r.st != dfr_pkg::DFR_ST_RUN || new_code == dfr_pkg::FC_NONE))
    |=> $stable(r.hist);
  endproperty
  a_hist_guard: assert property (p_hist_guard) // [RQ15]
    else $error("history cleared while guarded");

  property p_latched;
    @(posedge clock) disable iff (!reset_n)
    (r.st == dfr_pkg::DFR_ST_TRIP && !key_edge && !clr_held) |=>
    r.st == dfr_pkg::DFR_ST_TRIP;
  endproperty
  a_latched: assert property (p_latched) // [RQ17]
    else $error("trip released without reset");

  c_trip: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(r.st == dfr_pkg::DFR_ST_TRIP));
  c_key_reset: cover property (@(posedge clock) disable iff (!reset_n)
    r.st == dfr_pkg::DFR_ST_TRIP && key_edge);
  c_flicker: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(err_flicker));
  c_irq: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(irq));

endmodule // dfr_manager

// ---- design/dfr_pkg.sv ----
package dfr_pkg;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_USB_INTERVAL = 4'h1;
  localparam logic [3:0] REG_RETRY_LIMIT = 4'h2;
  localparam logic [3:0] REG_HIST_CLEAR = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_HISTORY = 4'h5;
  localparam logic [3:0] REG_POWER_HOURS = 4'h6;
  localparam logic [3:0] REG_RUN_HOURS = 4'h7;
  localparam logic [3:0] REG_PANEL_HOURS = 4'h8;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h9;
  localparam logic [3:0] REG_IRQ_MASK = 4'hA;

  // ---------------------------------------------------------------
  // fields and values
  // ---------------------------------------------------------------
  localparam int CTRL_BRAKE_EN = 0;
  localparam int CTRL_GUARD_LSB = 1;
  localparam logic [1:0] GUARD_LOCKED = 2'h1;
  localparam logic [15:0] USB_CHECK_OFF = 16'h270F;
  localparam logic [15:0] HIST_CLEAR_CMD = 16'h0001;
  localparam logic [15:0] HOURS_DISPLAY_DIV = 16'h000A;
  localparam int EV_USB = 0;
  localparam int EV_BRAKE = 1;
  localparam int EV_INTERNAL = 2;
  localparam int EV_GROUP = 3;
  localparam int EV_RETRY = 4;
  localparam int EV_RESET_DONE = 5;
  localparam int EV_W = 6;

  // ---------------------------------------------------------------
  // fault codes (usb, group and retry codes are local values)
  // ---------------------------------------------------------------
  localparam logic [7:0] FC_NONE = 8'h00;
  localparam logic [7:0] FC_INTERNAL = 8'h0D;
  localparam logic [7:0] FC_GROUPED = 8'h0E;
  localparam logic [7:0] FC_BRAKE_BASE = 8'h44;
  localparam logic [7:0] FC_USB = 8'h30;
  localparam logic [7:0] FC_LINE = 8'h31;
  localparam logic [7:0] FC_ANALOG = 8'h32;
  localparam logic [7:0] FC_INRUSH = 8'h33;
  localparam logic [7:0] FC_PE2 = 8'h34;
  localparam logic [7:0] FC_RETRY = 8'h35;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint TICK_TIME_PS = 64'd100_000_000_000;
  localparam longint CLEAR_HOLD_PS = 64'd100_000_000_000;
  localparam longint RESET_TIME_PS = 64'd1_000_000_000_000;
  localparam longint HOUR_TIME_PS = 64'd3_600_000_000_000_000;
  localparam int TICK_CYCLES_DEF = int'(TICK_TIME_PS / CLK_PERIOD_PS);
  // strictly longer than the hold time
  localparam int CLEAR_CYCLES_DEF = int'(CLEAR_HOLD_PS / CLK_PERIOD_PS) + 1;
  localparam int RESET_TICKS = int'(RESET_TIME_PS / TICK_TIME_PS);
  localparam int HOUR_TICKS_DEF = int'(HOUR_TIME_PS / TICK_TIME_PS);

  typedef enum logic [2:0] {
    DFR_ST_RESET = 3'b001,
    DFR_ST_RUN = 3'b010,
    DFR_ST_TRIP = 3'b100
  } dfr_state_t;

endpackage

// ---- sim/dfr_panel_model.sv ----
`timescale 1ns/10ps
module dfr_panel_model (
  input wire logic clock,
  output logic usb_activity,
  output logic panel_stop_key,
  output logic external_clear_input
);
  // lines idle low between requests, as the terminals are open then
  initial
  begin
    usb_activity = 1'b0;
    panel_stop_key = 1'b0;
    external_clear_input = 1'b0;
  end

  task automatic press_key();
    @(posedge clock) panel_stop_key <= 1'b1;
    repeat (4) @(posedge clock);
    panel_stop_key <= 1'b0;
  endtask

  // a short hold must be refused, so the length is the caller's
  task automatic hold_clear(input int n);
    @(posedge clock) external_clear_input <= 1'b1;
    repeat (n) @(posedge clock);
    external_clear_input <= 1'b0;
  endtask

  task automatic usb_pulse();
    @(posedge clock) usb_activity <= 1'b1;
    repeat (3) @(posedge clock);
    usb_activity <= 1'b0;
  endtask
endmodule // dfr_panel_model

// ---- sim/test_drive_fault_reset_manager.sv ----
`timescale 1ns/10ps
module test_drive_fault_reset_manager;
  logic clock, reset_n, reg_wr, reg_rd, usb_activity, brake_seq_error;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv, hv;
  logic [1:0] brake_seq_sel;
  logic internal_circuit_fault, line_input_fault, analog_input_fault;
  logic inrush_overheat_fault, pe2_group_fault, retry_attempt;
  logic panel_stop_key, external_clear_input, legacy_panel, run_command;
  logic drive_stop, err_flicker, thermal_clear, reset_busy, irq;
  logic [7:0] panel_code;
  logic saw_thermal, saw_flicker;
  int miscompares, comparisons;
  int cycle_count;

  dfr_manager #(.TICK_CYCLES(20), .CLEAR_CYCLES(5), .HOUR_TICKS(4))
    dfr_manager_i (.*);
  dfr_panel_model dfr_panel_model_i (.*);

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (thermal_clear) saw_thermal <= 1'b1;
    if (err_flicker) saw_flicker <= 1'b1;
    if (reset_n) cycle_count <= cycle_count + 1;
  end

  task automatic check(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock) reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the read edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_busy(input logic v, input int n);
    for (int i = 0; i < n && reset_busy !== v; i++) @(posedge clock);
    #1 check("reset_busy", reset_busy, v);
    @(posedge clock);
  endtask

  // pins answer in three cycles; the usb timer needs whole ticks
  task automatic wait_trip(input logic [7:0] code);
    for (int i = 0; i < 200 && drive_stop !== 1'b1; i++) @(posedge clock);
    #1 check("panel_code", panel_code, code);
    @(posedge clock);
  endtask

  task automatic key_reset();
    saw_thermal = 1'b0;
    dfr_panel_model_i.press_key();
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 400);
    check("thermal_clear", saw_thermal, 1'b1);
    check("drive_stop", drive_stop, 1'b0);
  endtask

  task automatic retry_pulse();
    @(posedge clock) retry_attempt <= 1'b1;
    repeat (3) @(posedge clock);
    retry_attempt <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic t_reset();
    rd(dfr_pkg::REG_STATUS, rv);
    check("status", rv, 16'h0100);
    rd(dfr_pkg::REG_USB_INTERVAL, rv);
    check("usb_interval", rv, 16'h270F);
    rd(dfr_pkg::REG_CTRL, rv);
    check("ctrl", rv, 16'h0000);
    rd(4'hF, rv);
    check("unmapped", rv, 16'h0000);
    repeat (150) @(posedge clock);
    check("reset_busy", reset_busy, 1'b1);
    wait_busy(1'b0, 200);
    rd(dfr_pkg::REG_STATUS, rv);
    check("status", rv, 16'h0200);
    retry_pulse(); // limit 0: counted, never trips
    retry_pulse();
    repeat (100) @(posedge clock);
    check("drive_stop", drive_stop, 1'b0);
  endtask

  task automatic t_internal();
    wr(dfr_pkg::REG_IRQ_MASK, 16'h0004);
    dfr_panel_model_i.press_key();
    repeat (10) @(posedge clock);
    check("reset_busy", reset_busy, 1'b0);
    @(posedge clock) internal_circuit_fault <= 1'b1;
    wait_trip(dfr_pkg::FC_INTERNAL);
    check("irq", irq, 1'b1);
    rd(dfr_pkg::REG_IRQ_STATUS, rv);
    check("irq_status", rv, 16'h0024);
    wr(dfr_pkg::REG_IRQ_STATUS, 16'h0024);
    #1 check("irq", irq, 1'b0);
    @(posedge clock) internal_circuit_fault <= 1'b0;
    repeat (30) @(posedge clock);
    check("drive_stop", drive_stop, 1'b1);
    key_reset();
  endtask

  task automatic t_usb();
    wr(dfr_pkg::REG_USB_INTERVAL, 16'h0002);
    repeat (6) dfr_panel_model_i.usb_pulse();
    check("drive_stop", drive_stop, 1'b0);
    wait_trip(dfr_pkg::FC_USB);
    check("irq", irq, 1'b0);
    dfr_panel_model_i.hold_clear(3);
    repeat (10) @(posedge clock);
    check("reset_busy", reset_busy, 1'b0);
    saw_flicker = 1'b0;
    fork
      dfr_panel_model_i.hold_clear(80);
      begin
        repeat (75) @(posedge clock);
        check("reset_busy", reset_busy, 1'b1);
        check("flicker", saw_flicker, 1'b1);
      end
    join
    wr(dfr_pkg::REG_USB_INTERVAL, dfr_pkg::USB_CHECK_OFF);
    wait_busy(1'b0, 400);
  endtask

  task automatic t_brake();
    brake_seq_sel <= 2'h2;
    brake_seq_error <= 1'b1;
    repeat (10) @(posedge clock);
    check("drive_stop", drive_stop, 1'b0);
    wr(dfr_pkg::REG_CTRL, 16'h0001);
    wait_trip(8'h46);
    brake_seq_error <= 1'b0;
    key_reset();
  endtask

  task automatic t_group();
    legacy_panel <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      {pe2_group_fault, inrush_overheat_fault, analog_input_fault,
       line_input_fault} <= 4'h1 << i;
      wait_trip(dfr_pkg::FC_GROUPED);
      {pe2_group_fault, inrush_overheat_fault, analog_input_fault,
       line_input_fault} <= 4'h0;
      key_reset();
    end
    rd(dfr_pkg::REG_HISTORY, rv);
    check("history", rv, 16'h0E0E);
    wr(dfr_pkg::REG_CTRL, 16'h0002);
    wr(dfr_pkg::REG_HIST_CLEAR, dfr_pkg::HIST_CLEAR_CMD);
    rd(dfr_pkg::REG_HISTORY, rv);
    check("history", rv, 16'h0E0E);
    wr(dfr_pkg::REG_CTRL, 16'h0000);
    wr(dfr_pkg::REG_HIST_CLEAR, dfr_pkg::HIST_CLEAR_CMD);
    rd(dfr_pkg::REG_HISTORY, rv);
    check("history", rv, 16'h0000);
  endtask

  task automatic t_retry();
    wr(dfr_pkg::REG_RETRY_LIMIT, 16'h0002);
    retry_pulse();
    check("drive_stop", drive_stop, 1'b0);
    retry_pulse();
    wait_trip(8'h35);
    key_reset();
  endtask

  // reads 240 cycles apart: exactly three hours at 80 cycles each
  // start mid-hour so the panel read cannot straddle a step
  task automatic t_hours();
    while (cycle_count % 80 != 30) @(posedge clock);
    rd(dfr_pkg::REG_POWER_HOURS, hv);
    repeat (238) @(posedge clock);
    rd(dfr_pkg::REG_POWER_HOURS, rv);
    check("power_hours", rv - hv, 16'h0003);
    rd(dfr_pkg::REG_PANEL_HOURS, hv);
    check("panel_hours", hv, rv / 16'h000A);
  endtask

  task automatic results();
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    {reset_n, reg_wr, reg_rd, brake_seq_error, retry_attempt} = 5'h00;
    {internal_circuit_fault, line_input_fault, analog_input_fault} = 3'h0;
    {inrush_overheat_fault, pe2_group_fault, legacy_panel} = 3'h0;
    {reg_addr, reg_wdata, brake_seq_sel} = 22'h000000;
    run_command = 1'b1;
    saw_thermal = 1'b0;
    saw_flicker = 1'b0;
    repeat (5) @(posedge clock);
    // power comes back only once the panel shows nothing
    for (int i = 0; i < 5 && panel_code !== 8'h00; i++) @(posedge clock);
    check("panel_code", panel_code, 8'h00);
    check("drive_stop", drive_stop, 1'b1);
    reset_n <= 1'b1;
    t_reset();
    t_internal();
    t_usb();
    t_brake();
    t_group();
    t_retry();
    t_hours();
    results();
  end

  initial
  begin
    #(4 * 40000);
    miscompares++;
    results();
  end
endmodule // test_drive_fault_reset_manager
